// file: rtl/skipxor_core.sv
// execution core for the test-skip and xor-immediate instructions
//
// Behaviour
// RULE1: zero tested register discards prefetched next instruction, runs no-op instead.
// RULE2: test-skip takes one cycle without skip, two when skipping one word.
// RULE3: skipping a two-word instruction makes test-skip take three cycles.
// RULE4: access bit zero resolves address inside the fixed access bank.
// RULE5: access bit one uses bank select register for general purpose bank.
// RULE6: extended set with access bit zero treats addresses up to 95 as offsets.
// RULE7: test-skip never changes any status flag.
// RULE8: xor-immediate XORs working register with literal, writes back in final phase.
// RULE9: xor-immediate updates only negative and zero flags.
// RULE10: negative is result bit 7; zero set when whole result is zero.
`timescale 1ns/100ps

module skipxor_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // instruction stream, one word per instruction cycle
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_two_word,
  input  wire logic [1:0]  q_phase,
  // operand data returned by the register file for operand_addr
  input  wire logic [7:0]  operand_data,
  output logic             operand_ptr,
  output logic [11:0]      operand_addr,
  output logic [7:0]       operand_offset,
  output logic             skip_active,
  output logic [7:0]       acc_out,
  output logic [4:0]       status_out,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready
);

  // ==========================================================================
  // operand address resolution
  function automatic skipxor_pkg::operand_addr_t resolve(input logic       a_bit,
                                                         input logic [7:0] f,
                                                         input logic [3:0] bank,
                                                         input logic       ext_en);
    skipxor_pkg::operand_addr_t r;
    r = '0;
    if (a_bit) begin
      // RULE5 bank select
      r.addr = {bank, f};
    end else if (ext_en && f <= skipxor_pkg::INDEXED_MAX) begin
      // RULE6 indexed offset
      r.ptr_valid = 1'b1;
      r.offset    = f;
    end else if (f < skipxor_pkg::ACCESS_SPLIT) begin
      // RULE4 access bank low
      r.addr = {4'h0, f};
    end else begin
      r.addr = {skipxor_pkg::ACCESS_HI_BANK, f};
    end
    return r;
  endfunction

  // ==========================================================================
  // decode
  logic       is_test_skip;
  logic       is_xor_imm;
  logic       ext_en_r;
  logic [3:0] bank_r;
  logic       q_last;
  logic       q_first;
  skipxor_pkg::operand_addr_t opnd;

  assign is_test_skip = instr_word[15:9] == skipxor_pkg::OP_TEST_SKIP_HI;
  assign is_xor_imm   = instr_word[15:8] == skipxor_pkg::OP_XOR_IMM_HI;
  assign q_last       = q_phase == 2'h3;
  assign q_first      = q_phase == 2'h0;
  assign opnd         = resolve(instr_word[8], instr_word[7:0], bank_r, ext_en_r);
  assign operand_ptr    = opnd.ptr_valid;
  assign operand_addr   = opnd.addr;
  assign operand_offset = opnd.offset;

  // ==========================================================================
  // execution state
  skipxor_pkg::ex_state_t st_r, st_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [4:0] stat_r, stat_nxt;
  logic       pend_zero_r, pend_zero_nxt;
  logic [7:0] skips_r, skips_nxt;
  logic [7:0] xor_res;

  // AXI write side state
  logic        aw_hold_r, aw_hold_nxt;
  logic        w_hold_r, w_hold_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        ext_en_nxt;
  logic [3:0]  bank_nxt;
  logic        wr_go;
  logic        sw_acc;
  logic        sw_stat;

  assign xor_res = acc_r ^ instr_word[7:0];
  assign wr_go   = aw_hold_r && w_hold_r && !bvalid_r;
  assign sw_acc  = wr_go && aw_addr_r == skipxor_pkg::ADDR_ACC && w_strb_r[0];
  assign sw_stat = wr_go && aw_addr_r == skipxor_pkg::ADDR_STATUS && w_strb_r[0];

  always_comb begin
    st_nxt        = st_r;
    acc_nxt       = acc_r;
    stat_nxt      = stat_r;
    pend_zero_nxt = pend_zero_r;
    skips_nxt     = skips_r;
    if (sw_acc) begin
      acc_nxt = w_data_r[7:0];
    end
    if (sw_stat) begin
      stat_nxt = w_data_r[4:0];
    end
    case (st_r)
      skipxor_pkg::EX_NORMAL: begin
        if (instr_valid && is_test_skip && q_phase == 2'h2) begin
          // RULE7 flags untouched, only remember the test
          pend_zero_nxt = operand_data == 8'h00;
        end
        if (instr_valid && is_xor_imm && q_last) begin
          // RULE8 write back in last phase
          acc_nxt = xor_res;
          // RULE9 only n and z change
          // RULE10 n is bit 7, z on all zero
          stat_nxt[skipxor_pkg::STAT_N] = xor_res[7];
          stat_nxt[skipxor_pkg::STAT_Z] = xor_res == 8'h00;
        end
        if (instr_valid && is_test_skip && q_last && pend_zero_r) begin
          // RULE1 flush the prefetched word
          st_nxt    = skipxor_pkg::EX_FLUSH1;
          skips_nxt = skips_r + 8'h01;
        end
      end
      skipxor_pkg::EX_FLUSH1: begin
        // RULE2 one extra no-op cycle
        // RULE3 a second one for a two-word victim
        if (q_last) begin
          st_nxt = instr_two_word ? skipxor_pkg::EX_FLUSH2 : skipxor_pkg::EX_NORMAL;
        end
      end
      default: begin
        if (q_last) begin
          st_nxt = skipxor_pkg::EX_NORMAL;
        end
      end
    endcase
    if (st_r == skipxor_pkg::EX_NORMAL && q_first) begin
      pend_zero_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= skipxor_pkg::EX_NORMAL;
      acc_r       <= skipxor_pkg::ACC_RST;
      stat_r      <= skipxor_pkg::STATUS_RST;
      pend_zero_r <= 1'b0;
      skips_r     <= 8'h00;
    end else begin
      st_r        <= st_nxt;
      acc_r       <= acc_nxt;
      stat_r      <= stat_nxt;
      pend_zero_r <= pend_zero_nxt;
      skips_r     <= skips_nxt;
    end
  end

  assign skip_active = st_r != skipxor_pkg::EX_NORMAL;
  assign acc_out     = acc_r;
  assign status_out  = stat_r;

  // ==========================================================================
  // AXI4-Lite write channel
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ext_en_nxt  = ext_en_r;
    bank_nxt    = bank_r;
    if (s_awvalid && s_awready) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_wdata;
      w_strb_nxt = s_wstrb;
    end
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = skipxor_pkg::RESP_OKAY;
      if (aw_addr_r == skipxor_pkg::ADDR_CTRL) begin
        if (w_strb_r[0]) ext_en_nxt = w_data_r[0];
      end else if (aw_addr_r == skipxor_pkg::ADDR_BANK) begin
        if (w_strb_r[0]) bank_nxt = w_data_r[3:0];
      end else if (aw_addr_r == skipxor_pkg::ADDR_ACC || aw_addr_r == skipxor_pkg::ADDR_STATUS) begin
        bresp_nxt = skipxor_pkg::RESP_OKAY;
      end else if (aw_addr_r != skipxor_pkg::ADDR_INFO) begin
        bresp_nxt = skipxor_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_r && s_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= skipxor_pkg::RESP_OKAY;
      ext_en_r  <= 1'b0;
      bank_r    <= skipxor_pkg::BANK_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      ext_en_r  <= ext_en_nxt;
      bank_r    <= bank_nxt;
    end
  end

  assign s_awready = !aw_hold_r;
  assign s_wready  = !w_hold_r;
  assign s_bvalid  = bvalid_r;
  assign s_bresp   = bresp_r;

  // ==========================================================================
  // AXI4-Lite read channel
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_arvalid && s_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = skipxor_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_araddr == skipxor_pkg::ADDR_CTRL) begin
        rdata_nxt = {31'h0, ext_en_r};
      end else if (s_araddr == skipxor_pkg::ADDR_BANK) begin
        rdata_nxt = {28'h0, bank_r};
      end else if (s_araddr == skipxor_pkg::ADDR_ACC) begin
        rdata_nxt = {24'h0, acc_r};
      end else if (s_araddr == skipxor_pkg::ADDR_STATUS) begin
        rdata_nxt = {27'h0, stat_r};
      end else if (s_araddr == skipxor_pkg::ADDR_INFO) begin
        rdata_nxt = {15'h0, skip_active, 8'h00, skips_r};
      end else begin
        rresp_nxt = skipxor_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= skipxor_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  assign s_arready = !rvalid_r;
  assign s_rvalid  = rvalid_r;
  assign s_rdata   = rdata_r;
  assign s_rresp   = rresp_r;

endmodule

// file: rtl/skipxor_pkg.sv
// package: constants and carrier types for the test-skip / xor-immediate execution block
package skipxor_pkg;

  // ==========================================================================
  // opcode encodings
  localparam logic [6:0] OP_TEST_SKIP_HI = 7'h33;   // 0110 011a, top seven bits
  localparam logic [7:0] OP_XOR_IMM_HI   = 8'h0a;   // 0000 1010
  localparam logic [7:0] INDEXED_MAX     = 8'h5f;   // highest indexed offset, 95
  localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;    // upper half of access bank
  localparam logic [7:0] ACCESS_SPLIT    = 8'h60;   // access bank low/high boundary

  // ==========================================================================
  // status flag positions
  localparam int unsigned STAT_N = 4;
  localparam int unsigned STAT_Z = 2;
  localparam logic [4:0]  STATUS_RST = 5'h00;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [3:0]  BANK_RST   = 4'h0;

  // ==========================================================================
  // register address bus map (AXI4-Lite)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;   // bit0 extended set enable
  localparam logic [7:0] ADDR_BANK   = 8'h04;   // bank select, 4 bits
  localparam logic [7:0] ADDR_ACC    = 8'h08;   // working register
  localparam logic [7:0] ADDR_STATUS = 8'h0c;   // status flags
  localparam logic [7:0] ADDR_INFO   = 8'h10;   // skip counter and skip-active flag
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EX_NORMAL,
    EX_FLUSH1,
    EX_FLUSH2
  } ex_state_t;

  typedef struct packed {
    logic        ptr_valid;   // resolved address is a pointer-relative offset
    logic [11:0] addr;        // resolved direct data address
    logic [7:0]  offset;      // indexed literal offset
  } operand_addr_t;

endpackage

// file: testbench/skipxor_props.sv
// checker: skip timing, flag and operand relations of skipxor_core
`timescale 1ns/100ps
module skipxor_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_two_word,
  input wire logic [1:0]  q_phase,
  input wire logic [7:0]  operand_data,
  input wire logic        operand_ptr,
  input wire logic [11:0] operand_addr,
  input wire logic [7:0]  operand_offset,
  input wire logic        skip_active,
  input wire logic [7:0]  acc_out,
  input wire logic [4:0]  status_out
);
  // ==========================================================================
  // decoded strobes
  wire       live  = instr_valid && !skip_active;
  wire       tskip = live && instr_word[15:9] == skipxor_pkg::OP_TEST_SKIP_HI;
  wire       xorq3 = live && q_phase == 2'h3 && instr_word[15:8] == skipxor_pkg::OP_XOR_IMM_HI;
  wire [7:0] f     = instr_word[7:0];
  // flags that the xor-immediate must leave alone
  wire [2:0] other_flags = {status_out[3], status_out[1:0]};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // operand is read in phase 2, the decision lands on the phase 3 edge
  sequence test_zero;
    tskip && q_phase == 2'h2 && operand_data == 8'h00 ##1 q_phase == 2'h3;
  endsequence
  sequence flush_first;
    $rose(skip_active) ##3 1'h1;
  endsequence
  chk_skip_entered: assert property (test_zero |=> skip_active)
    else $error("zero operand gave no flush");
  chk_skip_single: assert property (
    flush_first ##0 !instr_two_word |-> skip_active ##1 !skip_active)
    else $error("one-word flush length wrong");
  chk_skip_double: assert property (
    flush_first ##0 instr_two_word |=> skip_active [*4] ##1 !skip_active)
    else $error("two-word flush length wrong");
  chk_status_keep: assert property (
    (tskip && q_phase == 2'h3) || skip_active |=> $stable(status_out))
    else $error("status moved by test-skip");
  chk_xor_result: assert property (
    xorq3 |=> acc_out == ($past(acc_out) ^ $past(f)))
    else $error("xor result wrong");
  chk_xor_flags: assert property (
    xorq3 |=> status_out[skipxor_pkg::STAT_N] == acc_out[7]
      && status_out[skipxor_pkg::STAT_Z] == (acc_out == 8'h00)
      && other_flags == $past(other_flags))
    else $error("xor flags wrong");
  chk_access_bank: assert property (
    tskip && !instr_word[8] && !operand_ptr |-> operand_addr ==
      {(f >= skipxor_pkg::ACCESS_SPLIT) ? skipxor_pkg::ACCESS_HI_BANK : 4'h0, f})
    else $error("access bank address wrong");
  chk_indexed_offset: assert property (
    operand_ptr |-> !instr_word[8] && f <= skipxor_pkg::INDEXED_MAX && operand_offset == f)
    else $error("indexed offset wrong");
endmodule
bind skipxor_core skipxor_props skipxor_props_inst (
  .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
  .instr_two_word(instr_two_word), .q_phase(q_phase), .operand_data(operand_data),
  .operand_ptr(operand_ptr), .operand_addr(operand_addr), .operand_offset(operand_offset),
  .skip_active(skip_active), .acc_out(acc_out), .status_out(status_out)
);

// file: testbench/tb_skipxor_core.sv
// testbench: instruction stream and register bus checks of skipxor_core
`timescale 1ns/100ps
module tb_skipxor_core;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic        instr_valid = 1'h0;
  logic [15:0] instr_word = 16'h0000;
  logic        instr_two_word = 1'h0;
  logic [1:0]  q_phase = 2'h0;
  logic [7:0]  operand_data = 8'h00;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic        s_awvalid = 1'h0;
  logic        s_wvalid = 1'h0;
  logic        s_arvalid = 1'h0;
  logic        operand_ptr, skip_active, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [11:0] operand_addr;
  logic [7:0]  operand_offset, acc_out, acc_e;
  logic [4:0]  status_out, st_e;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  int          errors = 0, checks = 0, cyc = 0, fl = 0;
  // bready/rready stay high: the slave may answer at any edge
  skipxor_core skipxor_core_inst (
    .aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_two_word(instr_two_word), .q_phase(q_phase), .operand_data(operand_data),
    .operand_ptr(operand_ptr), .operand_addr(operand_addr), .operand_offset(operand_offset),
    .skip_active(skip_active), .acc_out(acc_out), .status_out(status_out),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(1'h1), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(1'h1)
  );
  // ==========================================================================
  // clock, timeout, reporting
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ==========================================================================
  // register bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'h0;
      if (s_wvalid && s_wready) s_wvalid <= 1'h0;
    end while (!s_bvalid);
    cmp(s_bresp, er, "bresp");
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'h0;
    end while (!s_rvalid);
    cmp(s_rresp, er, "rresp");
    if (er == skipxor_pkg::RESP_OKAY) cmp(s_rdata, ed, "rdata");
  endtask
  // ==========================================================================
  // one instruction cycle; outputs of the previous one are judged mid phase 0
  task automatic exec(input logic [15:0] w, input logic [7:0] d, input logic two,
                      input logic [12:0] ea);
    for (int p = 0; p < 4; p++) begin
      instr_valid <= (w != 16'h0000);
      instr_word <= w;
      operand_data <= d;
      instr_two_word <= two;
      q_phase <= 2'(p);
      if (p == 0) begin
        @(negedge aclk);
        cmp(acc_out, acc_e, "acc");
        cmp(status_out, st_e, "status");
        cmp(skip_active, fl != 0, "skip");
        if (w[15:9] == skipxor_pkg::OP_TEST_SKIP_HI)
          cmp(operand_ptr ? {1'h1, 4'h0, operand_offset} : {1'h0, operand_addr}, ea, "addr");
      end
      @(posedge aclk);
    end
    if (fl != 0) fl = (fl == 1 && two) ? 2 : 0;
    else if (w[15:9] == skipxor_pkg::OP_TEST_SKIP_HI && d == 8'h00) fl = 1;
    else if (w[15:8] == skipxor_pkg::OP_XOR_IMM_HI) begin
      acc_e = acc_e ^ w[7:0];
      st_e[skipxor_pkg::STAT_N] = acc_e[7];
      st_e[skipxor_pkg::STAT_Z] = (acc_e == 8'h00);
    end
  endtask
  // ==========================================================================
  // tests
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(skipxor_pkg::ADDR_ACC, 32'h0, skipxor_pkg::RESP_OKAY);
    axr(skipxor_pkg::ADDR_STATUS, 32'h0, skipxor_pkg::RESP_OKAY);
    axr(8'h20, 32'h0, skipxor_pkg::RESP_SLVERR);
    axw(8'h24, 32'h1, skipxor_pkg::RESP_SLVERR);
    $display("test reset done");
    axw(skipxor_pkg::ADDR_ACC, 32'hb5, skipxor_pkg::RESP_OKAY);
    acc_e = 8'hb5;
    axw(skipxor_pkg::ADDR_STATUS, 32'h0b, skipxor_pkg::RESP_OKAY);
    st_e = 5'h0b;
    exec(16'h0aaf, 8'h00, 1'h0, 13'h0);
    exec(16'h0a1a, 8'h00, 1'h0, 13'h0);
    exec(16'h0a80, 8'h00, 1'h0, 13'h0);
    exec(16'h0000, 8'h00, 1'h0, 13'h0);
    axr(skipxor_pkg::ADDR_STATUS, {27'h0, st_e}, skipxor_pkg::RESP_OKAY);
    $display("test xor done");
    axw(skipxor_pkg::ADDR_BANK, 32'h3, skipxor_pkg::RESP_OKAY);
    exec(16'h6742, 8'h05, 1'h0, 13'h0342);
    exec(16'h0a0f, 8'h00, 1'h0, 13'h0);
    exec(16'h6742, 8'h00, 1'h0, 13'h0342);
    exec(16'h0a0f, 8'h00, 1'h0, 13'h0);
    exec(16'h6670, 8'h00, 1'h0, 13'h0f70);
    exec(16'h0a0f, 8'h00, 1'h1, 13'h0);
    exec(16'h0a0f, 8'h00, 1'h0, 13'h0);
    exec(16'h6620, 8'h07, 1'h0, 13'h0020);
    exec(16'h0000, 8'h00, 1'h0, 13'h0);
    $display("test skip done");
    // two zero tests taken above; the info word is read-only
    axr(skipxor_pkg::ADDR_INFO, 32'h0000_0002, skipxor_pkg::RESP_OKAY);
    axw(skipxor_pkg::ADDR_INFO, 32'h0000_0005, skipxor_pkg::RESP_OKAY);
    axr(skipxor_pkg::ADDR_INFO, 32'h0000_0002, skipxor_pkg::RESP_OKAY);
    axw(skipxor_pkg::ADDR_CTRL, 32'h1, skipxor_pkg::RESP_OKAY);
    exec(16'h665f, 8'h01, 1'h0, 13'h105f);
    exec(16'h6660, 8'h01, 1'h0, 13'h0f60);
    exec(16'h6710, 8'h01, 1'h0, 13'h0310);
    exec(16'h0000, 8'h00, 1'h0, 13'h0);
    $display("test indexed done");
    conclude();
  end
endmodule
